// [rtl/rvs_defines.svh]
// Purpose: Constants for the regulator serial slave and voltage selection
// Assumes: 40 MHz hclk, 8-bit control registers at word-aligned AHB addresses
// Notes:   Byte address of a register is four times its index
// Behaviour
// - The port is only a slave and works at 100 kbps and 400 kbps with one protocol.
// - Only 7-bit addresses are matched; 10-bit and general call get no answer.
// - The slave address comes from the strap: supply 0x08, float 0x09, ground 0x10, mid 0x11.
// - Each received byte is acknowledged by holding data low over the next clock high.
// - The data byte is written on the falling clock edge of its last bit.
// - With the enable pin low, serial writes do not change any register.
// - All registers stay reachable over the serial port while host control is off.
// - With host control set, the output follows the register level code whatever the pin.
// - With host control clear, pin low gives 0 V, else clock and select pins pick one of four.
// - A register enable bit turns the output on or off while host control is set, and resets to one.
// - Level code 0 to 15 maps 11 V to 20 V in 0.6 V steps.
`ifndef RVS_DEFINES_SVH
`define RVS_DEFINES_SVH

`define RVS_CTRL1_IDX    8'h00
`define RVS_CTRL2_IDX    8'h01
`define RVS_STAT_IDX     8'h02
`define RVS_SADDR_IDX    8'h03
`define RVS_IDX_W        2
`define RVS_CTRL1_RST    8'h08
`define RVS_CTRL2_RST    8'h09
`define RVS_HCS_BIT      7
`define RVS_CODE_MSB     4
`define RVS_CODE_LSB     1
`define RVS_OUT_EN_BIT   0

`define RVS_STRAP_VCC    2'h0
`define RVS_STRAP_FLOAT  2'h1
`define RVS_STRAP_GND    2'h2
`define RVS_STRAP_MID    2'h3
`define RVS_ADDR_VCC     7'h08
`define RVS_ADDR_FLOAT   7'h09
`define RVS_ADDR_GND     7'h10
`define RVS_ADDR_MID     7'h11
`define RVS_STRAP_SETTLE 2'h2

`define RVS_PIN_CODE_HH  4'he
`define RVS_PIN_CODE_HL  4'h6
`define RVS_PIN_CODE_LH  4'hc
`define RVS_PIN_CODE_LL  4'h4
`define RVS_DV_BASE      8'h6e
`define RVS_DV_STEP      8'h06

`define RVS_SYNC_W       6
`define RVS_BITS_PER_BYTE 4'h8

`endif

// [rtl/rvs_pkg.sv]
// Purpose: Types shared by the regulator serial slave
// Assumes: rvs_defines.svh supplies all numeric constants
// Notes:   State encodings follow a Gray path through a write
package rvs_pkg;

  typedef enum logic [3:0] {
    RVS_IDLE = 4'h0,
    RVS_ADDR = 4'h1,
    RVS_AACK = 4'h3,
    RVS_REG  = 4'h2,
    RVS_RACK = 4'h6,
    RVS_DATA = 4'h7,
    RVS_DACK = 4'h5,
    RVS_SKIP = 4'h4,
    RVS_TX   = 4'hc,
    RVS_TACK = 4'hd
  } rvs_i2c_e;

  typedef struct packed {
    logic [5:0] s1;
    logic [5:0] s2;
  } rvs_sync_s;

  typedef struct packed {
    logic [1:0]  strap_cnt;
    logic        strap_done;
    logic [6:0]  own_addr;
    logic        scl_d;
    logic        sda_d;
    rvs_i2c_e    st;
    logic [3:0]  bcnt;
    logic [7:0]  sh;
    logic        rw;
    logic        nack;
    logic [7:0]  ptr;
    logic        sda_oe;
    logic        sda_o;
    logic [7:0]  ctrl1;
    logic [7:0]  ctrl2;
    logic        ahb_wr;
    logic [1:0]  ahb_idx;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic [3:0]  out_code;
    logic        out_on;
    logic [7:0]  out_decivolt;
  } rvs_top_s;

endpackage : rvs_pkg

// [rtl/rvs_sync.sv]
// Purpose: Two-flop synchroniser for the pins entering the hclk domain
// Assumes: Inputs are asynchronous levels
// Notes:   Stage one feeds only stage two
`timescale 1ns/100ps
`include "rvs_defines.svh"
module rvs_sync (
  input  wire logic                    hclk,
  input  wire logic                    hresetn,
  input  wire logic [`RVS_SYNC_W-1:0]  d,
  output logic      [`RVS_SYNC_W-1:0]  q
);
  rvs_pkg::rvs_sync_s r_reg;
  rvs_pkg::rvs_sync_s r_next;

  always_comb begin
    r_next    = r_reg;
    r_next.s1 = d;
    r_next.s2 = r_reg.s1;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign q = r_reg.s2;
endmodule : rvs_sync

// [rtl/rvs_top.sv]
// Purpose: Two-wire slave port, control registers and output voltage selection
// Assumes: Single 40 MHz clock; scl, sda and pins sampled after two flops
// Notes:   Registers also reachable over AHB-Lite with zero wait states
`timescale 1ns/100ps
`include "rvs_defines.svh"
module rvs_top (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  input  wire logic        en_pin,
  input  wire logic        voltage_select_pin,
  input  wire logic [1:0]  addr_strap,
  output logic      [3:0]  output_level_code,
  output logic             regulated_output_on,
  output logic      [7:0]  regulated_output_dv
);

  rvs_pkg::rvs_top_s r_reg;
  rvs_pkg::rvs_top_s r_next;

  logic [`RVS_SYNC_W-1:0] sy;
  logic                   scl_s;
  logic                   sda_s;
  logic                   en_s;
  logic                   vsel_s;
  logic [1:0]             strap_s;
  logic                   scl_rise;
  logic                   scl_fall;
  logic                   bus_start;
  logic                   bus_stop;
  logic                   i2c_wr;
  logic                   i2c_busy;
  logic [7:0]             stat8;
  logic [7:0]             nxt_ptr;
  logic [7:0]             tx_byte;
  logic                   ahb_take;
  logic                   ahb_map;

  // Pins come from outside the clock domain
  rvs_sync u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d       ({addr_strap, voltage_select_pin, en_pin, sda_i, scl_i}),
    .q       (sy)
  );

  assign scl_s   = sy[0];
  assign sda_s   = sy[1];
  assign en_s    = sy[2];
  assign vsel_s  = sy[3];
  assign strap_s = sy[5:4];

  // Oversampling at 40 MHz covers both bus rates alike
  assign scl_rise  = !r_reg.scl_d && scl_s;
  assign scl_fall  = r_reg.scl_d && !scl_s;
  assign bus_start = r_reg.scl_d && scl_s && r_reg.sda_d && !sda_s;
  assign bus_stop  = r_reg.scl_d && scl_s && !r_reg.sda_d && sda_s;
  assign i2c_busy  = (r_reg.st != rvs_pkg::RVS_IDLE) && (r_reg.st != rvs_pkg::RVS_SKIP);

  assign ahb_take  = hsel && hready && htrans[1];
  assign ahb_map   = (haddr[31:4] == 28'h0000000);

  assign stat8 = {r_reg.out_on, en_s, i2c_busy, r_reg.ctrl1[`RVS_HCS_BIT], r_reg.out_code};

  function automatic logic [6:0] strap_addr(input logic [1:0] s);
    case (s)
      `RVS_STRAP_VCC:   strap_addr = `RVS_ADDR_VCC;
      `RVS_STRAP_FLOAT: strap_addr = `RVS_ADDR_FLOAT;
      `RVS_STRAP_GND:   strap_addr = `RVS_ADDR_GND;
      default:          strap_addr = `RVS_ADDR_MID;
    endcase
  endfunction : strap_addr

  function automatic logic [7:0] reg_read(
    input logic [7:0] idx,
    input logic [7:0] c1,
    input logic [7:0] c2,
    input logic [7:0] st,
    input logic [6:0] adr
  );
    case (idx)
      `RVS_CTRL1_IDX: reg_read = c1;
      `RVS_CTRL2_IDX: reg_read = c2;
      `RVS_STAT_IDX:  reg_read = st;
      `RVS_SADDR_IDX: reg_read = {1'b0, adr};
      default:        reg_read = 8'h00;
    endcase
  endfunction : reg_read

  function automatic logic [7:0] decivolt(input logic [3:0] code);
    logic [7:0] prod;
    prod     = {4'h0, code} * `RVS_DV_STEP;
    decivolt = `RVS_DV_BASE + prod;
  endfunction : decivolt

  assign nxt_ptr = r_reg.ptr + 8'h01;
  assign tx_byte = reg_read(nxt_ptr, r_reg.ctrl1, r_reg.ctrl2, stat8, r_reg.own_addr);

  always_comb begin
    r_next        = r_reg;
    i2c_wr        = 1'b0;
    r_next.scl_d  = scl_s;
    r_next.sda_d  = sda_s;
    r_next.sda_o  = 1'b0;
    r_next.ahb_wr = 1'b0;

    // Strap is caught once, after the synchroniser has filled
    if (!r_reg.strap_done) begin
      r_next.strap_cnt = r_reg.strap_cnt + 2'h1;
      if (r_reg.strap_cnt == `RVS_STRAP_SETTLE) begin
        r_next.strap_done = 1'b1;
        r_next.own_addr   = strap_addr(strap_s);
      end
    end

    // Start and stop win over any byte in flight
    if (bus_start) begin
      r_next.st     = rvs_pkg::RVS_ADDR;
      r_next.bcnt   = 4'h0;
      r_next.sda_oe = 1'b0;
    end else if (bus_stop) begin
      r_next.st     = rvs_pkg::RVS_IDLE;
      r_next.sda_oe = 1'b0;
    end else begin
      case (r_reg.st)
        rvs_pkg::RVS_ADDR, rvs_pkg::RVS_REG, rvs_pkg::RVS_DATA: begin
          if (scl_rise) begin
            r_next.sh   = {r_reg.sh[6:0], sda_s};
            r_next.bcnt = r_reg.bcnt + 4'h1;
          end else if (scl_fall && r_reg.bcnt == `RVS_BITS_PER_BYTE) begin
            r_next.bcnt = 4'h0;
            case (r_reg.st)
              rvs_pkg::RVS_ADDR: begin
                // General call is 0 and never equals a strapped address
                if (r_reg.strap_done && r_reg.sh[7:1] == r_reg.own_addr) begin
                  r_next.rw     = r_reg.sh[0];
                  r_next.st     = rvs_pkg::RVS_AACK;
                  r_next.sda_oe = 1'b1;
                end else begin
                  r_next.st     = rvs_pkg::RVS_SKIP;
                  r_next.sda_oe = 1'b0;
                end
              end
              rvs_pkg::RVS_REG: begin
                r_next.ptr    = r_reg.sh;
                r_next.st     = rvs_pkg::RVS_RACK;
                r_next.sda_oe = 1'b1;
              end
              default: begin
                i2c_wr        = en_s;
                r_next.st     = rvs_pkg::RVS_DACK;
                r_next.sda_oe = 1'b1;
              end
            endcase
          end
        end
        rvs_pkg::RVS_AACK: begin
          if (scl_fall) begin
            if (r_reg.rw) begin
              r_next.sh     = reg_read(r_reg.ptr, r_reg.ctrl1, r_reg.ctrl2, stat8,
                                       r_reg.own_addr);
              r_next.sda_oe = ~r_next.sh[7];
              r_next.bcnt   = 4'h0;
              r_next.st     = rvs_pkg::RVS_TX;
            end else begin
              r_next.sda_oe = 1'b0;
              r_next.st     = rvs_pkg::RVS_REG;
            end
          end
        end
        rvs_pkg::RVS_RACK: begin
          if (scl_fall) begin
            r_next.sda_oe = 1'b0;
            r_next.st     = rvs_pkg::RVS_DATA;
          end
        end
        rvs_pkg::RVS_DACK: begin
          // Further bytes land in the following registers
          if (scl_fall) begin
            r_next.sda_oe = 1'b0;
            r_next.ptr    = nxt_ptr;
            r_next.st     = rvs_pkg::RVS_DATA;
          end
        end
        rvs_pkg::RVS_TX: begin
          if (scl_fall) begin
            if (r_reg.bcnt == 4'h7) begin
              r_next.sda_oe = 1'b0;
              r_next.bcnt   = 4'h0;
              r_next.st     = rvs_pkg::RVS_TACK;
            end else begin
              r_next.sh     = {r_reg.sh[6:0], 1'b0};
              r_next.sda_oe = ~r_reg.sh[6];
              r_next.bcnt   = r_reg.bcnt + 4'h1;
            end
          end
        end
        rvs_pkg::RVS_TACK: begin
          if (scl_rise) begin
            r_next.nack = sda_s;
          end else if (scl_fall) begin
            if (!r_reg.nack) begin
              r_next.ptr    = nxt_ptr;
              r_next.sh     = tx_byte;
              r_next.sda_oe = ~tx_byte[7];
              r_next.st     = rvs_pkg::RVS_TX;
            end else begin
              r_next.st     = rvs_pkg::RVS_SKIP;
            end
          end
        end
        rvs_pkg::RVS_IDLE, rvs_pkg::RVS_SKIP: begin
          r_next.sda_oe = 1'b0;
        end
        default: begin
          r_next.st     = rvs_pkg::RVS_IDLE;
          r_next.sda_oe = 1'b0;
        end
      endcase
    end

    // Serial write takes the slot; an AHB write in the same cycle is dropped
    if (i2c_wr) begin
      case (r_reg.ptr)
        `RVS_CTRL1_IDX: r_next.ctrl1 = r_reg.sh;
        `RVS_CTRL2_IDX: r_next.ctrl2 = r_reg.sh;
        default:        r_next.ctrl1 = r_reg.ctrl1;
      endcase
    end else if (r_reg.ahb_wr) begin
      case ({6'h00, r_reg.ahb_idx})
        `RVS_CTRL1_IDX: r_next.ctrl1 = hwdata[7:0];
        `RVS_CTRL2_IDX: r_next.ctrl2 = hwdata[7:0];
        default:        r_next.ctrl1 = r_reg.ctrl1;
      endcase
    end

    // Read data reflects a write finishing in this same cycle
    if (ahb_take) begin
      r_next.ahb_idx = haddr[3:2];
      if (hwrite) begin
        r_next.ahb_wr = ahb_map;
        r_next.hrdata = 32'h00000000;
      end else if (ahb_map) begin
        r_next.hrdata = {24'h000000, reg_read({6'h00, haddr[3:2]}, r_next.ctrl1,
                                               r_next.ctrl2, stat8, r_reg.own_addr)};
      end else begin
        r_next.hrdata = 32'h00000000;
      end
    end
    r_next.hreadyout = 1'b1;
    r_next.hresp     = 1'b0;

    // Pin mode follows scl, so bus traffic moves the output unless host control is set or the enable pin is low
    if (r_reg.ctrl1[`RVS_HCS_BIT]) begin
      r_next.out_code = r_reg.ctrl1[`RVS_CODE_MSB:`RVS_CODE_LSB];
      r_next.out_on   = r_reg.ctrl2[`RVS_OUT_EN_BIT];
    end else if (en_s) begin
      r_next.out_on = 1'b1;
      case ({scl_s, vsel_s})
        2'h3:    r_next.out_code = `RVS_PIN_CODE_HH;
        2'h2:    r_next.out_code = `RVS_PIN_CODE_HL;
        2'h1:    r_next.out_code = `RVS_PIN_CODE_LH;
        default: r_next.out_code = `RVS_PIN_CODE_LL;
      endcase
    end else begin
      r_next.out_on = 1'b0;
    end
    r_next.out_decivolt = r_next.out_on ? decivolt(r_next.out_code) : 8'h00;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r_reg           <= '0;
      r_reg.st        <= rvs_pkg::RVS_IDLE;
      r_reg.ctrl1     <= `RVS_CTRL1_RST;
      r_reg.ctrl2     <= `RVS_CTRL2_RST;
      r_reg.scl_d     <= 1'b1;
      r_reg.sda_d     <= 1'b1;
      r_reg.hreadyout <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign hreadyout           = r_reg.hreadyout;
  assign hresp               = r_reg.hresp;
  assign hrdata              = r_reg.hrdata;
  assign sda_o               = r_reg.sda_o;
  assign sda_oe              = r_reg.sda_oe;
  assign output_level_code   = r_reg.out_code;
  assign regulated_output_on = r_reg.out_on;
  assign regulated_output_dv = r_reg.out_decivolt;

endmodule : rvs_top

// [verif/rvs_checker.sv]
// Purpose: Port-level assertions for the regulator serial slave
// Assumes: Sees only rvs_top ports; one clock domain
// Notes:   Ack bounds leave room for bus clocks down to 100 kbps
`timescale 1ns/100ps
module rvs_checker (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        scl_i,
  input wire logic        sda_o,
  input wire logic        sda_oe,
  input wire logic [3:0]  output_level_code,
  input wire logic        regulated_output_on,
  input wire logic [7:0]  regulated_output_dv
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence ack_held;
    sda_oe [*8];
  endsequence
  // One bus clock period at the slowest rate fits well inside the bound
  sequence ack_gone;
    ##[1:1000] !sda_oe;
  endsequence

  slave_only_a: assert property (sda_o == 1'b0)
    else $error("data line driven high");
  oe_clock_low_a: assert property ($changed(sda_oe) |-> !scl_i)
    else $error("data pull changed while bus clock high");
  ack_hold_a: assert property ($rose(sda_oe) |-> ack_held)
    else $error("acknowledge pull too short");
  ack_bound_a: assert property ($rose(sda_oe) |-> ack_gone)
    else $error("acknowledge pull never released");
  level_map_a: assert property ($stable(output_level_code) && $stable(regulated_output_on)
    |-> regulated_output_dv == (regulated_output_on ? 8'h6e + 8'h06 * output_level_code : 8'h00))
    else $error("output voltage does not match level code");
  zero_wait_a: assert property (hreadyout == 1'b1)
    else $error("register bus wait state");
  resp_okay_a: assert property (hresp == 1'b0)
    else $error("register bus error response");
  rdata_upper_a: assert property (hrdata[31:8] == 24'h000000)
    else $error("read data upper bits set");
endmodule : rvs_checker

bind rvs_top rvs_checker u_chk (.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout),
  .hresp(hresp), .hrdata(hrdata), .scl_i(scl_i), .sda_o(sda_o), .sda_oe(sda_oe),
  .output_level_code(output_level_code), .regulated_output_on(regulated_output_on),
  .regulated_output_dv(regulated_output_dv));

// [verif/rvs_i2c_master.sv]
// Purpose: Two-wire bus master that writes and reads registers through the slave port
// Assumes: Open-drain data line resolved with a pull-up in the bench
// Notes:   Clock stands high between frames; half_cyc sets the rate
`timescale 1ns/100ps
module rvs_i2c_master (
  input  wire logic  hclk,
  input  wire logic  sda,
  output logic       scl,
  output logic       sda_low,
  output logic [2:0] acks,
  output logic [7:0] rdat
);
  int half_cyc;
  initial begin
    half_cyc = 50;
    scl = 1'b1;
    sda_low = 1'b0;
    acks = 3'h0;
    rdat = 8'h00;
  end
  task automatic pause(input int n);
    repeat (n * half_cyc / 2) @(posedge hclk);
  endtask : pause
  // Data moves only mid-low so a bit never looks like start or stop
  task automatic slot(input logic b, output logic seen);
    pause(1);
    sda_low <= !b;
    pause(1);
    scl <= 1'b1;
    pause(1);
    seen = sda;
    pause(1);
    scl <= 1'b0;
  endtask : slot
  task automatic write(input logic [6:0] sa, input logic [7:0] idx, input logic [7:0] d);
    logic [23:0] f;
    logic        s;
    f = {sa, 1'b0, idx, d};
    sda_low <= 1'b1;
    pause(2);
    scl <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      for (int j = 23 - 8 * i; j > 15 - 8 * i; j--) slot(f[j], s);
      slot(1'b1, s);
      acks[2 - i] <= !s;
    end
    pause(1);
    sda_low <= 1'b1;
    pause(1);
    scl <= 1'b1;
    pause(2);
    sda_low <= 1'b0;
    pause(2);
  endtask : write
  // Index set by a write frame, then a repeated start turns the bus round for one byte
  task automatic read(input logic [6:0] sa, input logic [7:0] idx);
    logic [23:0] f;
    logic [7:0]  d;
    logic        s;
    f = {sa, 1'b0, idx, sa, 1'b1};
    d = 8'h00;
    sda_low <= 1'b1;
    pause(2);
    scl <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      if (i == 2) begin
        pause(1);
        sda_low <= 1'b0;
        pause(1);
        scl <= 1'b1;
        pause(1);
        sda_low <= 1'b1;
        pause(1);
        scl <= 1'b0;
      end
      for (int j = 23 - 8 * i; j > 15 - 8 * i; j--) slot(f[j], s);
      slot(1'b1, s);
      acks[2 - i] <= !s;
    end
    for (int j = 7; j >= 0; j--) begin
      slot(1'b1, s);
      d[j] = s;
    end
    // A single byte ends with no acknowledge so the slave lets go of the data line
    slot(1'b1, s);
    rdat <= d;
    pause(1);
    sda_low <= 1'b1;
    pause(1);
    scl <= 1'b1;
    pause(2);
    sda_low <= 1'b0;
    pause(2);
  endtask : read
endmodule : rvs_i2c_master

// [verif/rvs_top_tb_top.sv]
// Purpose: Self-checking bench for the regulator serial slave
// Assumes: 40 MHz hclk; master model gives fast and standard bus rates
// Notes:   Monitor compares queued notes on read data or a look strobe
`timescale 1ns/100ps
module rvs_top_tb_top;
  typedef struct {
    string       what;
    logic [31:0] v;
    logic [31:0] m;
  } rvs_note_s;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        en_pin = 1'b1;
  logic        vsel = 1'b0;
  logic [1:0]  strap = 2'h0;
  logic        look = 1'b0;
  logic        rd_dp = 1'b0;
  logic [7:0]  rnd = 8'h02;
  logic [7:0]  val;
  logic [31:0] obs;
  int          failures = 0;
  int          compares = 0;
  rvs_note_s   exp_q[$];
  rvs_note_s   e;
  logic [6:0]  saddr [4] = '{7'h08, 7'h09, 7'h10, 7'h11};
  logic [6:0]  bad [3] = '{7'h10, 7'h00, 7'h78};
  logic [3:0]  pcode [4] = '{4'h4, 4'hc, 4'h6, 4'he};
  wire         hreadyout, hresp, sda_o, sda_oe, on, scl, m_low, sda;
  wire [31:0]  hrdata;
  wire [3:0]   code;
  wire [7:0]   dv;
  wire [2:0]   acks;
  wire [7:0]   rdat;

  always #12.5 hclk = ~hclk;
  assign sda = !(m_low | sda_oe);
  assign obs = {8'h0, rdat, acks, on, dv, code};

  rvs_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe), .en_pin(en_pin), .voltage_select_pin(vsel),
    .addr_strap(strap), .output_level_code(code), .regulated_output_on(on),
    .regulated_output_dv(dv));
  rvs_i2c_master m (.hclk(hclk), .sda(sda), .scl(scl), .sda_low(m_low), .acks(acks),
    .rdat(rdat));

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  function automatic logic [31:0] lvl(input logic o, input logic [3:0] c);
    return {19'h0, o, o ? 8'h6e + 8'h06 * c : 8'h00, c};
  endfunction : lvl
  task automatic stop_test;
    if (failures == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask : ahb
  task automatic rd(input logic [31:0] a, input logic [7:0] v);
    exp_q.push_back('{"hrdata", {24'h0, v}, 32'hffffffff});
    ahb(1'b0, a, 32'h0);
  endtask : rd
  // Levels and the last frame's acks are both taken on one look strobe
  task automatic peek(input string w, input logic [31:0] v, input logic [31:0] k);
    exp_q.push_back('{w, v, k});
    look <= 1'b1;
    @(posedge hclk);
    look <= 1'b0;
    @(posedge hclk);
  endtask : peek
  task automatic restart(input logic [1:0] s);
    strap <= s;
    hresetn <= 1'b0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (8) @(posedge hclk);
  endtask : restart
  task automatic sw(input logic [6:0] sa, input logic [7:0] i, input logic [7:0] d);
    m.write(sa, i, d);
    repeat (4) @(posedge hclk);
  endtask : sw
  // Serial read back: three acks and the returned byte are checked on one look
  task automatic sr(input logic [6:0] sa, input logic [7:0] i, input logic [7:0] v);
    m.read(sa, i);
    repeat (4) @(posedge hclk);
    peek("serial read", {8'h00, v, 16'he000}, 32'h00ffe000);
  endtask : sr

  always @(posedge hclk) begin
    if (rd_dp || look) begin
      if (exp_q.size() == 0) begin
        failures++;
        $display("mismatch queue expected note seen none");
      end else begin
        e = exp_q.pop_front();
        compares++;
        if (((rd_dp ? hrdata : obs) & e.m) !== e.v) begin
          failures++;
          $display("mismatch %s expected %h seen %h", e.what, e.v, (rd_dp ? hrdata : obs) & e.m);
        end
      end
    end
    rd_dp <= hsel && hreadyout && htrans[1] && !hwrite;
  end

  // Span is about 1.7 times the expected run length
  initial begin
    repeat (90000) @(posedge hclk);
    failures++;
    stop_test();
  end

  initial begin
    for (int s = 0; s < 4; s++) begin
      restart(s[1:0]);
      rd(32'h0c, {1'b0, saddr[s]});
      rd(32'h00, 8'h08);
      rd(32'h04, 8'h09);
      rnd = lfsr(rnd);
      val = rnd | 8'h01;
      sw(saddr[s], 8'h01, val);
      peek("acks", 32'he000, 32'he000);
      rd(32'h04, val);
      sr(saddr[s], 8'h01, val);
    end
    for (int i = 0; i < 4; i++) begin
      m.scl <= i[1];
      vsel <= i[0];
      repeat (8) @(posedge hclk);
      peek("pin level", lvl(1'b1, pcode[i]), 32'h1fff);
    end
    en_pin <= 1'b0;
    repeat (8) @(posedge hclk);
    peek("pin off", 32'h0, 32'h1ff0);
    sw(saddr[3], 8'h00, 8'h9e);
    rd(32'h00, 8'h08);
    en_pin <= 1'b1;
    rnd = lfsr(rnd);
    val = {1'b1, 2'h0, rnd[3:0], 1'b0};
    sw(saddr[3], 8'h00, val);
    rd(32'h00, val);
    peek("host level", lvl(1'b1, rnd[3:0]), 32'h1fff);
    en_pin <= 1'b0;
    vsel <= rnd[7];
    repeat (8) @(posedge hclk);
    peek("host level", lvl(1'b1, rnd[3:0]), 32'h1fff);
    ahb(1'b1, 32'h04, 32'h0);
    repeat (4) @(posedge hclk);
    peek("host off", 32'h0, 32'h1ff0);
    rd(32'h08, {4'h1, rnd[3:0]});
    en_pin <= 1'b1;
    foreach (bad[k]) begin
      sw(bad[k], 8'h00, 8'h00);
      peek("acks", 32'h0, 32'he000);
    end
    rd(32'h00, val);
    m.half_cyc = 200;
    rnd = lfsr(rnd);
    val = {1'b1, 2'h0, rnd[3:0], 1'b0};
    sw(saddr[3], 8'h00, val);
    peek("acks", 32'he000, 32'he000);
    rd(32'h00, val);
    ahb(1'b1, 32'h0c, 32'hff);
    rd(32'h0c, {1'b0, saddr[3]});
    repeat (2) @(posedge hclk);
    stop_test();
  end
endmodule : rvs_top_tb_top
